//--- ora_otp_region.sv
`timescale 1ns/1ps
// What this block does
// R1 - otp read: opcode, address, dummy, data out
// R2 - read address never wraps at top
// R3 - separate otp space, 33 lockable regions
// R4 - lower serial region factory written, locked
// R5 - upper serial region blank unless ordered
// R6 - locked region never changes again
// R7 - otp access ends at power-up, reset, deselect
// R8 - program outside otp range is discarded
// R9 - read outside range returns undefined data
// R10 - no otp access during internal program/erase
// R11 - acceleration disabled during otp commands
// R12 - page-program framing, reprogram allowed, no erase
// R13 - lock byte 0x100 bits 0,1 lock serials
// R14 - lock byte 0x100 bits 2-7 unprogrammable
// R15 - bit 7 at 0x215 unprogrammable
// R16 - host waits power-up delay before commands
// R17 - power-up in standby, write latch cleared
// R18 - supply below minimum ignores all commands
// R19 - delivered array reads FF, registers 00
// R20 - program carries exactly one data byte
// R21 - write enable precedes every otp program
// R22 - programming only clears bits to zero
// R23 - locked target region discards whole program
// R24 - fixed range decode, outside is invalid
module ora_otp_region import ora_pkg::*; #(
	parameter logic [63:0] LOWER_SERIAL_VALUE = 64'h0123456789ABCDEF, // arbitrary value
	parameter bit          UPPER_ID_ORDERED   = 1'b0,
	parameter logic [63:0] UPPER_ID_VALUE     = 64'h0F1E2D3C4B5A6978  // arbitrary value
) (
	input  logic         core_clk,         // 10 MHz core clock
	input  logic         rst,              // synchronous reset, high
	input  ora_pins_type pins,             // serial pins, asynchronous
	output logic         so,               // serial data out
	output logic         soEn,             // so output enable, high drives
	output logic         accelProgActive,  // acceleration applied to programming
	input  logic [1:0]   avs_address,      // word index
	input  logic         avs_read,         // read strobe
	input  logic         avs_write,        // write strobe
	input  logic [31:0]  avs_writedata,    // write data
	output logic [31:0]  avs_readdata,     // read data
	output logic         avs_waitrequest   // low for the cycle that completes
);

	logic [7:0]    otpMem [OTP_DEPTH];
	ora_pins_type  pinS1_r, pinS2_r;
	logic          sckPrev_r, csPrev_r;
	ora_state_type state_r, state_nxt;
	logic [4:0]    bitCnt_r, bitCnt_nxt;
	logic [1:0]    byteCnt_r, byteCnt_nxt;
	logic [7:0]    shift_r, dataR_r;
	logic [23:0]   addr_r;
	logic          isProg_r, otpActive_r, wel_r;
	logic [PU_CNT_W-1:0] puCnt_r;
	logic          ready_r, progDone_r, progDrop_r;
	logic [31:0]   ctrl_r;
	logic          so_r, soEn_r, accel_r, wait_r;
	logic [31:0]   rdData_r;
	logic [8:0]    progIdx_r;
	logic [7:0]    progOld_r;

	// address to region id, REGION_NONE where no data region sits
	function automatic logic [5:0] regionOf(input logic [23:0] a);
		logic [23:0] offs;
		offs = 24'h000000;
		if (a >= LOWER_SERIAL_FIRST && a <= LOWER_SERIAL_LAST) begin
			return REGION_LOWER;
		end else if (a >= UPPER_SERIAL_FIRST && a <= UPPER_SERIAL_LAST) begin
			return REGION_UPPER;
		end else if (a >= REGION_A_FIRST && a <= REGION_A_LAST) begin
			offs = a - REGION_A_FIRST;
			return REGION_A_BASE + {2'b00, offs[7:4]};
		end else if (a >= REGION_B_FIRST && a <= REGION_B_LAST) begin
			offs = a - REGION_B_FIRST;
			return REGION_B_BASE + {2'b00, offs[7:4]};
		end else if (a >= SHORT_REGION_FIRST && a <= SHORT_REGION_LAST) begin
			return REGION_SHORT;
		end
		return REGION_NONE;
	endfunction : regionOf

	// which bits of a byte may be programmed, zero means invalid target
	function automatic logic [7:0] progMaskOf(input logic [23:0] a);
		if (a == SERIAL_LOCK_ADDR) begin
			return SERIAL_LOCK_MASK; // see R14
		end else if (a == LOCK_B_TOP_ADDR) begin
			return TOP_LOCK_MASK; // see R15
		end else if (a == LOCK_A_ADDR || a == LOCK_A_ADDR + 24'h000001 || a == LOCK_B_ADDR) begin
			return FULL_MASK;
		end else if (regionOf(a) != REGION_NONE) begin
			return FULL_MASK;
		end
		return 8'h00; // see R8, R24
	endfunction : progMaskOf

	// memory index of an otp address
	function automatic logic [8:0] memIdx(input logic [23:0] a);
		logic [23:0] offs;
		offs = a - OTP_FIRST;
		return offs[8:0];
	endfunction : memIdx

	// factory content: erased, lower serial written and locked
	initial begin
		for (int i = 0; i < OTP_DEPTH; i++) begin
			otpMem[i] = ERASED_BYTE; // see R19
		end
		for (int i = 0; i < 8; i++) begin
			otpMem[memIdx(LOWER_SERIAL_FIRST) + 9'(i)] = LOWER_SERIAL_VALUE[8*i +: 8]; // see R4
			if (UPPER_ID_ORDERED) begin
				otpMem[memIdx(UPPER_SERIAL_FIRST) + 9'(i)] = UPPER_ID_VALUE[8*i +: 8]; // see R5
			end
		end
		otpMem[memIdx(SERIAL_LOCK_ADDR)] = UPPER_ID_ORDERED ? 8'hFC : SERIAL_LOCK_INIT; // see R13
	end

	// pin synchronisers, first stage read only by the second
	always_ff @(posedge core_clk) begin
		pinS1_r <= pins;
		pinS2_r <= pinS1_r;
	end

	// edge history of the synchronised clock and select
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sckPrev_r <= 1'b0;
			csPrev_r  <= 1'b1;
		end else begin
			sckPrev_r <= pinS2_r.sck;
			csPrev_r  <= pinS2_r.csN;
		end
	end

	// edge and decode wires
	wire       sckRise   = pinS2_r.sck & ~sckPrev_r;
	wire       sckFall   = ~pinS2_r.sck & sckPrev_r;
	wire       csActive  = ~pinS2_r.csN;
	wire       csRise    = pinS2_r.csN & ~csPrev_r;
	wire [7:0] opcode    = {shift_r[6:0], pinS2_r.si};
	wire       opLast    = state_r == S_IDLE && sckRise && bitCnt_r == BYTE_LAST_BIT;
	wire       isOtpOp   = opcode == OTP_READ_CMD || opcode == OTP_PROGRAM_CMD;
	wire       supplyOk  = ctrl_r[CTRL_SUPPLY];
	wire       embBusy   = ctrl_r[CTRL_EMB_BUSY];
	wire       canAccept = supplyOk && ready_r; // see R16, R18
	wire       inRange   = addr_r >= OTP_FIRST && addr_r <= OTP_LAST;
	wire [8:0] curIdx    = memIdx(addr_r);
	wire [7:0] rdByte    = inRange ? otpMem[curIdx] : ERASED_BYTE; // see R9
	wire [2:0] bitSel    = 3'h7 - bitCnt_r[2:0];

	// lock lookup for the target region
	wire [5:0]  tgtRegion = regionOf(addr_r);
	wire [5:0]  lockN     = (tgtRegion >= REGION_B_BASE) ? tgtRegion - REGION_B_BASE :
	                        tgtRegion - REGION_A_BASE;
	wire [23:0] lockAddr  = (tgtRegion <= REGION_UPPER) ? SERIAL_LOCK_ADDR :
	                        (tgtRegion >= REGION_B_BASE) ? LOCK_B_ADDR + {23'h000000, lockN[3]} :
	                        LOCK_A_ADDR + {23'h000000, lockN[3]};
	wire [2:0]  lockBit   = (tgtRegion <= REGION_UPPER) ? tgtRegion[2:0] : lockN[2:0]; // see R13
	wire [7:0]  lockByte  = otpMem[memIdx(lockAddr)];
	wire        tgtLocked = tgtRegion != REGION_NONE && !lockByte[lockBit]; // see R6, R23
	wire [7:0]  progMask  = progMaskOf(addr_r);
	wire        oneByte   = byteCnt_r == 2'h1 && bitCnt_r == 5'h00; // see R20
	wire        progEnd   = csRise && isProg_r && state_r == S_WRITE;
	wire        progGo    = progEnd && oneByte && wel_r && !tgtLocked &&
	                        progMask != 8'h00 && !embBusy && supplyOk; // see R8, R10, R21, R23

	// command sequencer on sampled serial clock edges
	always_comb begin
		state_nxt   = state_r;
		bitCnt_nxt  = bitCnt_r;
		byteCnt_nxt = byteCnt_r;
		if (!csActive) begin
			state_nxt   = S_IDLE; // see R7
			bitCnt_nxt  = 5'h00;
			byteCnt_nxt = 2'h0;
		end else if (sckRise) begin
			bitCnt_nxt = bitCnt_r + 5'h01;
			case (state_r)
				S_IDLE: begin
					if (bitCnt_r == BYTE_LAST_BIT) begin
						bitCnt_nxt = 5'h00;
						if (isOtpOp && canAccept && !embBusy) begin
							state_nxt = S_ADDR; // see R1, R12
						end else begin
							state_nxt = S_SKIP; // see R10, R18
						end
					end
				end
				S_ADDR: begin
					if (bitCnt_r == ADDR_LAST_BIT) begin
						bitCnt_nxt = 5'h00;
						state_nxt  = isProg_r ? S_WRITE : S_DUMMY;
					end
				end
				S_DUMMY: begin
					if (bitCnt_r == DUMMY_LAST_BIT) begin
						bitCnt_nxt = 5'h00;
						state_nxt  = S_READ;
					end
				end
				S_READ, S_WRITE: begin
					if (bitCnt_r == BYTE_LAST_BIT) begin
						bitCnt_nxt = 5'h00;
						if (byteCnt_r != 2'h3) begin
							byteCnt_nxt = byteCnt_r + 2'h1; // saturates, two means too many
						end
					end
				end
				S_SKIP: begin
					bitCnt_nxt = bitCnt_r;
				end
				default: begin
					state_nxt = S_SKIP;
				end
			endcase
		end
	end

	// sequencer state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_r   <= S_IDLE;
			bitCnt_r  <= 5'h00;
			byteCnt_r <= 2'h0;
		end else begin
			state_r   <= state_nxt;
			bitCnt_r  <= bitCnt_nxt;
			byteCnt_r <= byteCnt_nxt;
		end
	end

	// bit shifter, address and program data capture
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shift_r <= 8'h00;
			addr_r  <= 24'h000000;
			dataR_r <= ERASED_BYTE;
		end else if (csActive && sckRise) begin
			shift_r <= opcode;
			if (state_r == S_ADDR) begin
				addr_r <= {addr_r[22:0], pinS2_r.si};
			end else if (state_r == S_READ && bitCnt_r == BYTE_LAST_BIT) begin
				addr_r <= addr_r + 24'h000001; // see R2, plain increment, no wrap
			end
			if (state_r == S_WRITE && bitCnt_r == BYTE_LAST_BIT) begin
				dataR_r <= opcode;
			end
		end
	end

	// otp mode flag and command kind, dropped on every deselect
	always_ff @(posedge core_clk) begin
		if (rst) begin
			otpActive_r <= 1'b0; // see R7
			isProg_r    <= 1'b0;
		end else if (!csActive) begin
			otpActive_r <= 1'b0; // see R7
			isProg_r    <= 1'b0;
		end else if (opLast && isOtpOp && canAccept && !embBusy) begin
			otpActive_r <= 1'b1; // see R3
			isProg_r    <= opcode == OTP_PROGRAM_CMD;
		end
	end

	// write enable latch, cleared at power-up, by write disable and by each otp program that reaches its data phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wel_r <= 1'b0; // see R17
		end else if (progEnd) begin
			wel_r <= 1'b0; // see R21
		end else if (opLast && canAccept && opcode == WRITE_ENABLE_CMD) begin
			wel_r <= 1'b1;
		end else if (opLast && canAccept && opcode == WRITE_DISABLE_CMD) begin
			wel_r <= 1'b0;
		end
	end

	// cell write: and-in only, so bits only go from one to zero; no erase path
	// plain always, since the factory load in the initial block shares this array
	always @(posedge core_clk) begin
		if (progGo) begin
			otpMem[curIdx] <= otpMem[curIdx] & (dataR_r | ~progMask); // see R12, R14, R15, R22
		end
	end

	// outcome of the last program command
	always_ff @(posedge core_clk) begin
		if (rst) begin
			progDone_r <= 1'b0;
			progDrop_r <= 1'b0;
		end else if (progEnd) begin
			progDone_r <= progGo;
			progDrop_r <= ~progGo;
		end
	end

	// power-up delay: commands before it count are ignored
	always_ff @(posedge core_clk) begin
		if (rst) begin
			puCnt_r <= '0;
			ready_r <= 1'b0; // see R17, R18
		end else if (!ready_r) begin
			puCnt_r <= puCnt_r + 1'b1;
			ready_r <= puCnt_r == PU_CNT_W'(POWER_UP_CYCLES - 1);
		end
	end

	// serial output: bit changes on the falling clock edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			so_r   <= 1'b0;
			soEn_r <= 1'b0;
		end else begin
			soEn_r <= csActive && state_r == S_READ;
			if (csActive && sckFall && state_r == S_READ) begin
				so_r <= rdByte[bitSel]; // see R1
			end
		end
	end

	// acceleration only outside otp commands
	always_ff @(posedge core_clk) begin
		if (rst) begin
			accel_r <= 1'b0;
		end else begin
			accel_r <= pinS2_r.accelHv && !otpActive_r && canAccept; // see R11
		end
	end

	// bus decode
	wire        busReq   = (avs_read || avs_write) && wait_r;
	wire        busWrite = avs_write && !wait_r;
	wire [31:0] statusWord = {26'h0000000, accel_r, progDrop_r, progDone_r,
	                          ready_r, otpActive_r, wel_r};
	wire [31:0] busRdMux = (avs_address == REG_CTRL)   ? ctrl_r :
	                       (avs_address == REG_STATUS) ? statusWord : 32'h00000000;

	// bus slave: one wait cycle, then the completing cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wait_r   <= 1'b1;
			rdData_r <= 32'h00000000;
		end else begin
			wait_r   <= !busReq;
			rdData_r <= busReq ? busRdMux : rdData_r;
		end
	end

	// control register; unmapped writes fall away
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_r <= CTRL_RESET;
		end else if (busWrite && avs_address == REG_CTRL) begin
			ctrl_r <= {30'h00000000, avs_writedata[CTRL_EMB_BUSY], avs_writedata[CTRL_SUPPLY]};
		end
	end

	assign so              = so_r;
	assign soEn            = soEn_r;
	assign accelProgActive = accel_r;
	assign avs_readdata    = rdData_r;
	assign avs_waitrequest = wait_r;

	// helper capture for the one-way bit check
	always_ff @(posedge core_clk) begin
		progIdx_r <= curIdx;
		progOld_r <= otpMem[curIdx];
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_otp_mode_exit: assert property (csRise |=> !otpActive_r) // see R7
		else $error("otp mode still active after deselect");
	a_busy_denies_otp: assert property (opLast && embBusy && isOtpOp |=> state_r == S_SKIP) // see R10
		else $error("otp command accepted while internal operation runs");
	a_accel_off_otp: assert property (otpActive_r |=> !accel_r) // see R11
		else $error("acceleration active during otp command");
	a_prog_needs_latch: assert property (progGo |-> wel_r ##1 !wel_r) // see R21
		else $error("program without write enable or latch not cleared");
	a_lock_blocks_prog: assert property (progEnd && tgtLocked |=> progDrop_r && !progDone_r &&
		otpMem[progIdx_r] == progOld_r) // see R23
		else $error("program to locked region not discarded");
	a_bits_only_clear: assert property (progGo |=> (otpMem[progIdx_r] & ~progOld_r) == 8'h00) // see R22
		else $error("program raised a bit to one");
	a_serial_lock_rsvd: assert property (progGo && addr_r == SERIAL_LOCK_ADDR |=>
		otpMem[0][7:2] == $past(otpMem[0][7:2])) // see R14
		else $error("reserved lock bits changed");
	a_top_lock_bit7: assert property (progGo && addr_r == LOCK_B_TOP_ADDR |=>
		otpMem[9'h115][7] == $past(otpMem[9'h115][7])) // see R15
		else $error("bit 7 of top lock byte changed");
	a_single_byte_only: assert property (progEnd && !oneByte |=> progDrop_r && !progDone_r) // see R20
		else $error("program with wrong byte count not discarded");
	a_quiet_before_ready: assert property (!ready_r && opLast |=> state_r == S_SKIP) // see R18
		else $error("command accepted before power-up delay");
	a_bus_one_wait: assert property ((avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r)
		else $error("bus answer not after one wait cycle");

	c_otp_read_data: cover property (state_r == S_DUMMY ##[1:200] state_r == S_READ);
	c_otp_program: cover property (progGo);
	c_locked_discard: cover property (progEnd && tgtLocked);
	c_busy_deny: cover property (opLast && embBusy && isOtpOp);

endmodule : ora_otp_region

//--- ora_pkg.sv
package ora_pkg;

	// core clock and power-up timing
	localparam int unsigned CLK_FREQ_HZ       = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_FREQ_HZ;
	localparam int unsigned POWER_UP_DELAY_NS = 300_000;
	// longest time, so round down, never below one cycle
	localparam int unsigned POWER_UP_CYCLES   = (POWER_UP_DELAY_NS / CLK_PERIOD_NS > 0) ?
	                                            POWER_UP_DELAY_NS / CLK_PERIOD_NS : 1;
	localparam int unsigned PU_CNT_W          = 12;

	// serial command codes
	localparam logic [7:0] OTP_READ_CMD     = 8'h4B;
	localparam logic [7:0] OTP_PROGRAM_CMD  = 8'h42;
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
	localparam logic [4:0] ADDR_LAST_BIT    = 5'h17;
	localparam logic [4:0] DUMMY_LAST_BIT   = 5'h07;
	localparam logic [4:0] BYTE_LAST_BIT    = 5'h07;

	// otp address space
	localparam logic [23:0] OTP_FIRST          = 24'h000100;
	localparam logic [23:0] OTP_LAST           = 24'h0002FF;
	localparam int unsigned OTP_DEPTH          = 512;
	localparam logic [23:0] SERIAL_LOCK_ADDR   = 24'h000100;
	localparam logic [23:0] LOWER_SERIAL_FIRST = 24'h000102;
	localparam logic [23:0] LOWER_SERIAL_LAST  = 24'h000109;
	localparam logic [23:0] UPPER_SERIAL_FIRST = 24'h00010A;
	localparam logic [23:0] UPPER_SERIAL_LAST  = 24'h000111;
	localparam logic [23:0] LOCK_A_ADDR        = 24'h000112;
	localparam logic [23:0] REGION_A_FIRST     = 24'h000114;
	localparam logic [23:0] REGION_A_LAST      = 24'h000213;
	localparam logic [23:0] LOCK_B_ADDR        = 24'h000214;
	localparam logic [23:0] LOCK_B_TOP_ADDR    = 24'h000215;
	localparam logic [23:0] REGION_B_FIRST     = 24'h000216;
	localparam logic [23:0] REGION_B_LAST      = 24'h0002F5;
	localparam logic [23:0] SHORT_REGION_FIRST = 24'h0002F6;
	localparam logic [23:0] SHORT_REGION_LAST  = 24'h0002FF;
	localparam logic [5:0]  REGION_LOWER       = 6'h00;
	localparam logic [5:0]  REGION_UPPER       = 6'h01;
	localparam logic [5:0]  REGION_A_BASE      = 6'h02;
	localparam logic [5:0]  REGION_B_BASE      = 6'h12;
	localparam logic [5:0]  REGION_SHORT       = 6'h20;
	localparam logic [5:0]  REGION_NONE        = 6'h3F;
	localparam logic [7:0]  SERIAL_LOCK_MASK   = 8'h03;
	localparam logic [7:0]  TOP_LOCK_MASK      = 8'h7F;
	localparam logic [7:0]  FULL_MASK          = 8'hFF;
	localparam logic [7:0]  ERASED_BYTE        = 8'hFF;
	localparam logic [7:0]  SERIAL_LOCK_INIT   = 8'hFE;

	// register map, word index on the bus, byte address is four times it
	localparam logic [1:0]  REG_CTRL      = 2'h0;
	localparam logic [1:0]  REG_STATUS    = 2'h1;
	localparam logic [31:0] CTRL_RESET    = 32'h00000001;
	localparam int unsigned CTRL_SUPPLY   = 0;
	localparam int unsigned CTRL_EMB_BUSY = 1;
	localparam int unsigned ST_WEL        = 0;
	localparam int unsigned ST_OTP_ACTIVE = 1;
	localparam int unsigned ST_READY      = 2;
	localparam int unsigned ST_PROG_DONE  = 3;
	localparam int unsigned ST_PROG_DROP  = 4;
	localparam int unsigned ST_ACCEL      = 5;

	typedef struct packed {
		logic csN;     // chip select, low active
		logic sck;     // serial clock
		logic si;      // serial data in
		logic accelHv; // high voltage sense of the protect/accel pin
	} ora_pins_type;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_ADDR  = 3'b001,
		S_DUMMY = 3'b010,
		S_READ  = 3'b011,
		S_WRITE = 3'b100,
		S_SKIP  = 3'b101
	} ora_state_type;

endpackage : ora_pkg

//--- ora_spi_host.sv
`timescale 1ns/1ps
// host side spi master, mode 0, msb first; sck stands low outside frames
module ora_spi_host import ora_pkg::*; (
	input  logic         core_clk, // paces the 800 ns serial clock
	input  logic         accelHv,  // accel pin level from bench
	input  logic         so,       // device data out
	input  logic         soEn,     // device drives so
	output ora_pins_type pins,     // chip select, clock, data in
	output logic         rxDone,   // one pulse per captured byte
	output logic [7:0]   rxByte    // captured byte
);
	logic csN;
	logic sck;
	logic si;

	assign pins = {csN, sck, si, accelHv};

	// idle levels from time zero
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rxDone = 1'b0;
		rxByte = 8'h00;
	end

	// so lags each fall by a few core cycles, so sample just before the next fall
	task automatic xbyte(input logic [7:0] tx, input bit cap);
		logic [7:0] r;
		for (int i = 7; i >= 0; i--) begin
			@(posedge core_clk);
			if (i < 7) r[i+1] = soEn ? so : 1'bx;
			sck <= 1'b0;
			si <= tx[i];
			repeat (4) @(posedge core_clk);
			sck <= 1'b1;
			repeat (3) @(posedge core_clk);
		end
		@(posedge core_clk);
		r[0] = soEn ? so : 1'bx;
		sck <= 1'b0;
		if (cap) begin
			rxByte <= r;
			rxDone <= 1'b1;
			@(posedge core_clk);
			rxDone <= 1'b0;
		end
	endtask : xbyte

	// select, then give the synchroniser time to see it
	task automatic begin_frame();
		@(posedge core_clk);
		csN <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : begin_frame

	// released data line toggles so a stale level is never trusted
	task automatic end_frame();
		@(posedge core_clk);
		csN <= 1'b1;
		si <= ~si;
		repeat (12) @(posedge core_clk);
	endtask : end_frame

	task automatic send_addr(input logic [23:0] a);
		for (int k = 2; k >= 0; k--) xbyte(a[8*k +: 8], 1'b0);
	endtask : send_addr

	task automatic prog(input logic [23:0] a, input logic [15:0] d, input int nb, input bit write_enable_cmd);
		if (write_enable_cmd) begin
			begin_frame();
			xbyte(WRITE_ENABLE_CMD, 1'b0);
			end_frame();
		end
		begin_frame();
		xbyte(OTP_PROGRAM_CMD, 1'b0);
		send_addr(a);
		for (int k = nb; k > 0; k--) xbyte(d[8*k-1 -: 8], 1'b0);
		end_frame();
	endtask : prog

	task automatic rd(input logic [23:0] a, input int n);
		begin_frame();
		xbyte(OTP_READ_CMD, 1'b0);
		send_addr(a);
		xbyte(8'h00, 1'b0);
		repeat (n) xbyte(8'h00, 1'b1);
		end_frame();
	endtask : rd
endmodule : ora_spi_host

//--- ora_otp_region_tb.sv
`timescale 1ns/1ps
// main thread drives and notes expectations, monitor compares results
module ora_otp_region_tb import ora_pkg::*;;
	logic         core_clk, rst, accelHv, rxDone, so, soEn, accelProgActive;
	logic [1:0]   avs_address;
	logic         avs_read, avs_write, avs_waitrequest;
	logic [31:0]  avs_writedata, avs_readdata;
	logic [7:0]   rxByte, rnd;
	ora_pins_type pins;
	int           failCount, totalChecks;
	string        nameQ[$];
	logic [31:0]  expQ[$], mskQ[$];

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	ora_otp_region i_ora_otp_region (.core_clk(core_clk), .rst(rst), .pins(pins), .so(so),
		.soEn(soEn), .accelProgActive(accelProgActive), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	ora_spi_host i_ora_spi_host (.core_clk(core_clk), .accelHv(accelHv), .so(so), .soEn(soEn),
		.pins(pins), .rxDone(rxDone), .rxByte(rxByte));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			failCount++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic take(input logic [31:0] g);
		if (expQ.size() == 0) begin
			failCount++;
			$display("FAIL unexpected result expected none seen %h", g);
		end else chk(nameQ.pop_front(), expQ.pop_front(), g & mskQ.pop_front());
	endtask : take

	// every result shown by the design is matched against the oldest note
	always @(posedge core_clk) begin
		if (rxDone === 1'b1) take({24'h000000, rxByte});
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) take(avs_readdata);
	end

	// hold the request until waitrequest is seen low at an edge
	task automatic bus(input bit wr, input logic [1:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) chk("avs_waitrequest", 32'h0, {31'h0, avs_waitrequest});
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rdReg(input logic [1:0] a, input logic [31:0] e, input logic [31:0] m);
		nameQ.push_back($sformatf("register %0d", a));
		expQ.push_back(e);
		mskQ.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask : rdReg

	task automatic otpRd(input logic [23:0] a, input int n, input logic [23:0] e);
		for (int k = n - 1; k >= 0; k--) begin
			nameQ.push_back($sformatf("otp byte %h", a + 24'(n - 1 - k)));
			expQ.push_back({24'h000000, e[8*k +: 8]});
			mskQ.push_back(32'h000000FF);
		end
		i_ora_spi_host.rd(a, n);
	endtask : otpRd

	task automatic pg(input logic [23:0] a, input logic [15:0] d, input int nb, input bit write_enable_cmd);
		i_ora_spi_host.prog(a, d, nb, write_enable_cmd);
	endtask : pg

	task automatic endOfTest();
		// a noted result that never showed up is a mismatch as well
		if (expQ.size() != 0) chk("pending results", 32'h0, 32'(expQ.size()));
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : endOfTest

	// watchdog sized well past the planned traffic
	initial begin
		repeat (90000) @(posedge core_clk);
		chk("watchdog", 32'h0, 32'h1);
		endOfTest();
	end

	initial begin
		rst = 1'b1;
		accelHv = 1'b0;
		avs_address = 2'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		failCount = 0;
		totalChecks = 0;
		rnd = 8'h14;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rdReg(REG_STATUS, 32'h0, 32'hFFFFFFFF);
		rdReg(REG_CTRL, CTRL_RESET, 32'hFFFFFFFF);
		bus(1'b1, 2'h3, 32'hFFFFFFFF);
		rdReg(2'h3, 32'h0, 32'hFFFFFFFF);
		rdReg(2'h2, 32'h0, 32'hFFFFFFFF);
		repeat (POWER_UP_CYCLES) @(posedge core_clk);
		rdReg(REG_STATUS, 32'h4, 32'hFFFFFFFF);
		otpRd(SERIAL_LOCK_ADDR, 1, 24'hFE);
		otpRd(UPPER_SERIAL_FIRST, 2, 24'hFFFF);
		otpRd(24'h000120, 2, 24'hFFFF);
		pg(24'h000114, 16'hA5, 1, 1'b1);
		rdReg(REG_STATUS, 32'hC, 32'hFFFFFFFF);
		otpRd(24'h000114, 1, 24'hA5);
		pg(24'h000114, 16'h0F, 1, 1'b1);
		otpRd(24'h000114, 1, 24'h05);
		pg(24'h000115, 16'h00, 1, 1'b0);
		rdReg(REG_STATUS, 32'h14, 32'hFFFFFFFF);
		pg(24'h000115, 16'h0000, 2, 1'b1);
		otpRd(24'h000115, 1, 24'hFF);
		pg(24'h000300, 16'h00, 1, 1'b1);
		rdReg(REG_STATUS, 32'h14, 32'h1E);
		pg(LOCK_A_ADDR, 16'hFE, 1, 1'b1);
		pg(24'h000115, 16'h00, 1, 1'b1);
		rdReg(REG_STATUS, 32'h14, 32'h1E);
		otpRd(24'h000114, 3, 24'h05FFFF);
		pg(SERIAL_LOCK_ADDR, 16'h00, 1, 1'b1);
		otpRd(SERIAL_LOCK_ADDR, 1, 24'hFC);
		pg(UPPER_SERIAL_FIRST, 16'h00, 1, 1'b1);
		otpRd(UPPER_SERIAL_FIRST, 1, 24'hFF);
		pg(LOWER_SERIAL_FIRST, 16'h00, 1, 1'b1);
		rdReg(REG_STATUS, 32'h14, 32'h1E);
		// only bit 7 asked to clear, so the short region stays unlocked
		pg(LOCK_B_TOP_ADDR, 16'h7F, 1, 1'b1);
		otpRd(LOCK_B_TOP_ADDR, 1, 24'hFF);
		otpRd(OTP_LAST, 2, 24'hFFFF);
		// random bytes through the short region, one cell each
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			pg(SHORT_REGION_FIRST + 24'(i), {8'h00, rnd}, 1, 1'b1);
			rdReg(REG_STATUS, 32'hC, 32'hFFFFFFFF);
			otpRd(SHORT_REGION_FIRST + 24'(i), 1, {16'h0000, rnd});
		end
		bus(1'b1, REG_CTRL, 32'h3);
		pg(24'h000120, 16'h00, 1, 1'b1);
		bus(1'b1, REG_CTRL, 32'h1);
		otpRd(24'h000120, 1, 24'hFF);
		bus(1'b1, REG_CTRL, 32'h0);
		pg(24'h000121, 16'h00, 1, 1'b1);
		bus(1'b1, REG_CTRL, 32'h1);
		otpRd(24'h000121, 1, 24'hFF);
		accelHv <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("accelProgActive", 32'h1, {31'h0, accelProgActive});
		fork
			otpRd(24'h000114, 1, 24'h05);
			begin
				repeat (200) @(posedge core_clk);
				chk("accelProgActive", 32'h0, {31'h0, accelProgActive});
			end
		join
		accelHv <= 1'b0;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		// write enable is allowed early, but must be ignored before ready
		i_ora_spi_host.begin_frame();
		i_ora_spi_host.xbyte(WRITE_ENABLE_CMD, 1'b0);
		i_ora_spi_host.end_frame();
		rdReg(REG_STATUS, 32'h0, 32'hFFFFFFFF);
		repeat (POWER_UP_CYCLES) @(posedge core_clk);
		otpRd(24'h000114, 1, 24'h05);
		repeat (10) @(posedge core_clk);
		endOfTest();
	end
endmodule : ora_otp_region_tb
